// ==== include/sbte_pkg.sv ====
// constants and types of the serial byte transfer engine
package sbte_pkg;
  // ****************************************************************
  // register indexes; byte address is four times the index
  // ****************************************************************
  localparam logic [31:0] SER_CTRL_IDX = 32'hFFFF81C2;
  localparam logic [31:0] DESC_BASE_IDX = 32'hFFFF8708;
  localparam logic [31:0] ACT_EN_IDX = 32'hFFFF8710;
  localparam logic [31:0] STATUS_IDX = 32'hFFFF8714;
  localparam logic [31:0] SER_CTRL_ADDR = SER_CTRL_IDX << 2;
  localparam logic [31:0] DESC_BASE_ADDR = DESC_BASE_IDX << 2;
  localparam logic [31:0] ACT_EN_ADDR = ACT_EN_IDX << 2;
  localparam logic [31:0] STATUS_ADDR = STATUS_IDX << 2;
  localparam logic [7:0] SER_CTRL_RST = 8'h00;
  localparam logic [15:0] DESC_BASE_RST = 16'h0000;
  localparam logic [15:0] ACT_EN_RST = 16'h0000;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int ACT_TX_BIT = 2;
  localparam int ACT_RX_BIT = 3;
  localparam int SC_TX_IRQ_ON = 7;
  localparam int SC_RX_IRQ_ON = 6;
  localparam int SC_TX_ON = 5;
  localparam int SC_RX_ON = 4;
  localparam int SC_MULTINODE_IRQ_ON = 3;
  localparam int SC_TX_DONE_IRQ_ON = 2;
  localparam logic [1:0] CKS_INT_PIN_IN = 2'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // ****************************************************************
  // descriptor layout and engine address space
  // ****************************************************************
  localparam logic [1:0] AM_FIXED = 2'h0;
  localparam logic [1:0] AM_INC = 2'h2;
  localparam logic [1:0] AM_DEC = 2'h3;
  localparam logic [1:0] KIND_NORMAL = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [31:0] TX_DESC_OFS = 32'h00000020;
  localparam logic [31:0] RX_DESC_OFS = 32'h00000030;
  localparam logic [1:0] DESC_LAST_WORD = 2'h2;
  localparam logic [31:0] TX_HOLD_ADDR = 32'hFFFF81C3;
  localparam logic [31:0] RX_HOLD_ADDR = 32'hFFFF81C5;

  typedef struct packed {
    logic [1:0] source_addr_mode;
    logic [1:0] dest_addr_step;
    logic [1:0] transfer_kind;
    logic [1:0] transfer_size;
    logic block_side_sel;
    logic chain_on;
    logic irq_every_transfer;
    logic nmi_behaviour;
    logic [3:0] spare;
  } sbte_mode_t;

  typedef struct packed {
    sbte_mode_t mode;
    logic [15:0] count;
    logic [31:0] source;
    logic [31:0] destination;
  } sbte_desc_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FETCH = 3'h1,
    ST_SUSP = 3'h2,
    ST_SRC = 3'h3,
    ST_DST = 3'h4,
    ST_WBACK = 3'h5,
    ST_DONE = 3'h6
  } sbte_state_t;
endpackage

// ==== design/sbte_engine.sv ====
// serial byte transfer engine: ahb-lite registers, descriptor engine, event gating
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/100ps

// Summary of operation
// - source mode 00 keeps the source address unchanged after every transfer.
// - destination mode 10 advances the destination address after each transfer.
// - transfer kind 00 selects normal transfer operation.
// - transfer size 00 moves exactly one byte per transfer.
// - block side select bit 7 is ignored in normal operation.
// - chain bit 0 means no further descriptor after the current one.
// - with bit 5 clear, interrupt only once the programmed count has finished.
// - with bit 4 clear, a pending transfer suspends while nmi is active.
// - count word holds the number of transfers still to perform.
// - each descriptor holds a 32-bit source address.
// - each descriptor holds a 32-bit destination address.
// - base register gives the upper 16 address bits of the descriptors.
// - activation bit 2 lets the transmit request start a transfer.
// - activation bit 3 lets the receive request start a transfer.
// - serial control bit 7 enables transmit-empty requests.
// - serial control bit 6 enables receive-full and receive-error requests.
// - serial control bit 5 enables the transmitter.
// - serial control bit 4 enables the receiver.
// - bit 3 acts only in asynchronous multinode mode.
// - serial control bit 2 clear suppresses transmit-end requests.
// - clock select 01 picks internal clock, serial clock pin as input.
// - 8-bit receive holding register keeps the latest byte, fixed source.
module sbte_engine (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [3:0] mem_be,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic tx_empty_evt,
  input wire logic rx_full_evt,
  input wire logic rx_err_evt,
  input wire logic tx_end_evt,
  input wire logic multinode_evt,
  input wire logic async_mode,
  input wire logic multinode_mode,
  input wire logic [7:0] rx_byte,
  input wire logic nmi,
  output logic [7:0] tx_byte,
  output logic tx_load,
  output logic tx_on,
  output logic rx_on,
  output logic clk_internal,
  output logic sck_dir_in,
  output logic tx_empty_irq,
  output logic rx_full_irq,
  output logic rx_error_irq,
  output logic tx_done_irq,
  output logic multinode_irq
);
  logic [31:0] hrdata_reg;
  logic ahb_wr_reg;
  logic [31:0] ahb_addr_reg;
  logic [7:0] ser_ctrl_reg;
  logic [15:0] desc_base_reg;
  logic [15:0] act_en_reg;
  logic [15:0] act_en_next;
  logic pend_tx_reg;
  logic pend_rx_reg;
  logic nmi_s1_reg;
  logic nmi_s2_reg;
  logic [7:0] rx_hold_reg;
  sbte_pkg::sbte_state_t state_reg;
  sbte_pkg::sbte_desc_t desc_reg;
  logic ch_rx_reg;
  logic [1:0] idx_reg;
  logic [7:0] data_reg;
  logic mem_req_reg;
  logic mem_we_reg;
  logic [31:0] mem_addr_reg;
  logic [31:0] mem_wdata_reg;
  logic [3:0] mem_be_reg;
  logic [7:0] tx_byte_reg;
  logic tx_load_reg;
  logic tx_on_reg;
  logic rx_on_reg;
  logic clk_internal_reg;
  logic sck_dir_in_reg;
  logic tx_irq_reg;
  logic rx_irq_reg;
  logic err_irq_reg;
  logic tend_irq_reg;
  logic mn_irq_reg;

  // ****************************************************************
  // ahb-lite slave: zero wait state, reads have no side effect
  // ****************************************************************
  wire ahb_go = hsel & hready & htrans[1] & (hsize == sbte_pkg::HSIZE_WORD);

  function automatic logic [31:0] rd_value(input logic [31:0] a);
    logic [31:0] v;
    v = 32'h00000000;
    if (a == sbte_pkg::SER_CTRL_ADDR) v = {24'h000000, ser_ctrl_reg};
    if (a == sbte_pkg::DESC_BASE_ADDR) v = {16'h0000, desc_base_reg};
    if (a == sbte_pkg::ACT_EN_ADDR) v = {16'h0000, act_en_reg};
    if (a == sbte_pkg::STATUS_ADDR) begin
      v = {16'h0000, rx_hold_reg, 2'h0, nmi_s2_reg, pend_rx_reg, pend_tx_reg, state_reg};
    end
    return v;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_wr_reg <= 1'b0;
      ahb_addr_reg <= 32'h00000000;
      hrdata_reg <= 32'h00000000;
    end else begin
      ahb_wr_reg <= ahb_go & hwrite;
      if (ahb_go) begin
        ahb_addr_reg <= haddr;
      end
      hrdata_reg <= (ahb_go & ~hwrite) ? rd_value(haddr) : 32'h00000000;
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  wire wr_sc = ahb_wr_reg & (ahb_addr_reg == sbte_pkg::SER_CTRL_ADDR);
  wire wr_base = ahb_wr_reg & (ahb_addr_reg == sbte_pkg::DESC_BASE_ADDR);
  wire wr_act = ahb_wr_reg & (ahb_addr_reg == sbte_pkg::ACT_EN_ADDR);
  wire fin_zero = (state_reg == sbte_pkg::ST_DONE) && (desc_reg.count == 16'h0000);

  // a channel that runs out is switched off even if software writes the same cycle
  always_comb begin
    act_en_next = wr_act ? hwdata[15:0] : act_en_reg;
    if (fin_zero) begin
      act_en_next[ch_rx_reg ? sbte_pkg::ACT_RX_BIT : sbte_pkg::ACT_TX_BIT] = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ser_ctrl_reg <= sbte_pkg::SER_CTRL_RST;
      desc_base_reg <= sbte_pkg::DESC_BASE_RST;
      act_en_reg <= sbte_pkg::ACT_EN_RST;
    end else begin
      if (wr_sc) ser_ctrl_reg <= hwdata[7:0];
      if (wr_base) desc_base_reg <= hwdata[15:0];
      act_en_reg <= act_en_next;
    end
  end

  // ****************************************************************
  // serial channel controls and receive holding register
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_on_reg <= 1'b0;
      rx_on_reg <= 1'b0;
      clk_internal_reg <= 1'b1;
      sck_dir_in_reg <= 1'b0;
      rx_hold_reg <= 8'h00;
    end else begin
      tx_on_reg <= ser_ctrl_reg[sbte_pkg::SC_TX_ON];
      rx_on_reg <= ser_ctrl_reg[sbte_pkg::SC_RX_ON];
      clk_internal_reg <= ~ser_ctrl_reg[1];
      sck_dir_in_reg <= (ser_ctrl_reg[1:0] == sbte_pkg::CKS_INT_PIN_IN);
      if (rx_full_evt) rx_hold_reg <= rx_byte;
    end
  end

  // ****************************************************************
  // request gating, pending flags and cpu interrupts
  // ****************************************************************
  wire tx_req = tx_empty_evt & ser_ctrl_reg[sbte_pkg::SC_TX_IRQ_ON];
  wire rx_req = rx_full_evt & ser_ctrl_reg[sbte_pkg::SC_RX_IRQ_ON];
  wire act_tx = act_en_reg[sbte_pkg::ACT_TX_BIT];
  wire act_rx = act_en_reg[sbte_pkg::ACT_RX_BIT];
  wire take_rx = (state_reg == sbte_pkg::ST_IDLE) & pend_rx_reg;
  wire take_tx = (state_reg == sbte_pkg::ST_IDLE) & ~pend_rx_reg & pend_tx_reg;
  wire fin_any = (state_reg == sbte_pkg::ST_DONE);
  wire fin_irq = fin_zero | (fin_any & desc_reg.mode.irq_every_transfer);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_tx_reg <= 1'b0;
      pend_rx_reg <= 1'b0;
    end else begin
      // a new request in the take cycle is kept: set wins over clear
      pend_tx_reg <= (pend_tx_reg & ~take_tx) | (tx_req & act_tx);
      pend_rx_reg <= (pend_rx_reg & ~take_rx) | (rx_req & act_rx);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_irq_reg <= 1'b0;
      rx_irq_reg <= 1'b0;
      err_irq_reg <= 1'b0;
      tend_irq_reg <= 1'b0;
      mn_irq_reg <= 1'b0;
    end else begin
      tx_irq_reg <= (tx_req & ~act_tx) | (fin_irq & ~ch_rx_reg);
      rx_irq_reg <= (rx_req & ~act_rx) | (fin_irq & ch_rx_reg);
      err_irq_reg <= rx_err_evt & ser_ctrl_reg[sbte_pkg::SC_RX_IRQ_ON];
      tend_irq_reg <= tx_end_evt & ser_ctrl_reg[sbte_pkg::SC_TX_DONE_IRQ_ON];
      mn_irq_reg <= multinode_evt & ser_ctrl_reg[sbte_pkg::SC_MULTINODE_IRQ_ON]
                    & async_mode & multinode_mode;
    end
  end

  // nmi is a pin: two flops before the engine looks at it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_s1_reg <= 1'b0;
      nmi_s2_reg <= 1'b0;
    end else begin
      nmi_s1_reg <= nmi;
      nmi_s2_reg <= nmi_s1_reg;
    end
  end

  // ****************************************************************
  // descriptor engine
  // ****************************************************************
  // only byte lanes move; larger sizes still step the address by their width
  function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] m,
                                       input logic [1:0] sz);
    logic [31:0] inc;
    inc = 32'h00000001 << sz;
    unique case (m)
      sbte_pkg::AM_INC: step = a + inc;
      sbte_pkg::AM_DEC: step = a - inc;
      default: step = a;
    endcase
  endfunction

  wire [31:0] desc_addr = {desc_base_reg, 16'h0000}
                          + (ch_rx_reg ? sbte_pkg::RX_DESC_OFS : sbte_pkg::TX_DESC_OFS)
                          + {28'h0000000, idx_reg, 2'h0};
  wire mem_done = mem_req_reg & mem_ack;
  wire [31:0] src_word = mem_rdata >> {desc_reg.source[1:0], 3'h0};
  logic [31:0] wb_word;

  always_comb begin
    unique case (idx_reg)
      2'h0: wb_word = {desc_reg.mode, desc_reg.count};
      2'h1: wb_word = desc_reg.source;
      default: wb_word = desc_reg.destination;
    endcase
  end

  // transfer_kind, block_side_sel and chain_on are held but all kinds run as normal
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= sbte_pkg::ST_IDLE;
      desc_reg <= '0;
      ch_rx_reg <= 1'b0;
      idx_reg <= 2'h0;
      data_reg <= 8'h00;
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= 32'h00000000;
      mem_wdata_reg <= 32'h00000000;
      mem_be_reg <= 4'h0;
      tx_byte_reg <= 8'h00;
      tx_load_reg <= 1'b0;
    end else begin
      tx_load_reg <= 1'b0;
      if (mem_done) mem_req_reg <= 1'b0;
      unique case (state_reg)
        sbte_pkg::ST_IDLE: begin
          if (pend_rx_reg | pend_tx_reg) begin
            ch_rx_reg <= pend_rx_reg;
            idx_reg <= 2'h0;
            state_reg <= sbte_pkg::ST_FETCH;
          end
        end
        sbte_pkg::ST_FETCH: begin
          if (!mem_req_reg) begin
            mem_req_reg <= 1'b1;
            mem_we_reg <= 1'b0;
            mem_addr_reg <= desc_addr;
            mem_be_reg <= 4'hF;
          end else if (mem_ack) begin
            idx_reg <= 2'(idx_reg + 2'h1);
            unique case (idx_reg)
              2'h0: {desc_reg.mode, desc_reg.count} <= mem_rdata;
              2'h1: desc_reg.source <= mem_rdata;
              default: desc_reg.destination <= mem_rdata;
            endcase
            if (idx_reg == sbte_pkg::DESC_LAST_WORD) begin
              state_reg <= sbte_pkg::ST_SUSP;
            end
          end
        end
        sbte_pkg::ST_SUSP: begin
          if (!nmi_s2_reg || desc_reg.mode.nmi_behaviour) begin
            state_reg <= sbte_pkg::ST_SRC;
          end
        end
        sbte_pkg::ST_SRC: begin
          if (desc_reg.source == sbte_pkg::RX_HOLD_ADDR) begin
            data_reg <= rx_hold_reg;
            state_reg <= sbte_pkg::ST_DST;
          end else if (!mem_req_reg) begin
            mem_req_reg <= 1'b1;
            mem_we_reg <= 1'b0;
            mem_addr_reg <= desc_reg.source;
            mem_be_reg <= 4'h0;
          end else if (mem_ack) begin
            data_reg <= src_word[7:0];
            state_reg <= sbte_pkg::ST_DST;
          end
        end
        sbte_pkg::ST_DST: begin
          if (desc_reg.destination == sbte_pkg::TX_HOLD_ADDR || mem_done) begin
            if (desc_reg.destination == sbte_pkg::TX_HOLD_ADDR) begin
              tx_byte_reg <= data_reg;
              tx_load_reg <= 1'b1;
            end
            desc_reg.source <= step(desc_reg.source, desc_reg.mode.source_addr_mode,
                                    desc_reg.mode.transfer_size);
            desc_reg.destination <= step(desc_reg.destination, desc_reg.mode.dest_addr_step,
                                         desc_reg.mode.transfer_size);
            desc_reg.count <= desc_reg.count - 16'h0001;
            idx_reg <= 2'h0;
            state_reg <= sbte_pkg::ST_WBACK;
          end else if (!mem_req_reg) begin
            mem_req_reg <= 1'b1;
            mem_we_reg <= 1'b1;
            mem_addr_reg <= desc_reg.destination;
            mem_wdata_reg <= {4{data_reg}};
            mem_be_reg <= 4'(4'h1 << desc_reg.destination[1:0]);
          end
        end
        sbte_pkg::ST_WBACK: begin
          if (!mem_req_reg) begin
            mem_req_reg <= 1'b1;
            mem_we_reg <= 1'b1;
            mem_addr_reg <= desc_addr;
            mem_wdata_reg <= wb_word;
            mem_be_reg <= 4'hF;
          end else if (mem_ack) begin
            idx_reg <= 2'(idx_reg + 2'h1);
            if (idx_reg == sbte_pkg::DESC_LAST_WORD) state_reg <= sbte_pkg::ST_DONE;
          end
        end
        sbte_pkg::ST_DONE: state_reg <= sbte_pkg::ST_IDLE;
        default: state_reg <= sbte_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign mem_req = mem_req_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign mem_be = mem_be_reg;
  assign tx_byte = tx_byte_reg;
  assign tx_load = tx_load_reg;
  assign tx_on = tx_on_reg;
  assign rx_on = rx_on_reg;
  assign clk_internal = clk_internal_reg;
  assign sck_dir_in = sck_dir_in_reg;
  assign tx_empty_irq = tx_irq_reg;
  assign rx_full_irq = rx_irq_reg;
  assign rx_error_irq = err_irq_reg;
  assign tx_done_irq = tend_irq_reg;
  assign multinode_irq = mn_irq_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking dcb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  wire step_done = (state_reg == sbte_pkg::ST_WBACK) && (idx_reg == 2'h0) && !mem_req_reg;

  a_src_fixed_hold: assert property (step_done && $past(state_reg) == sbte_pkg::ST_DST
      && desc_reg.mode.source_addr_mode == sbte_pkg::AM_FIXED
      |-> desc_reg.source == $past(desc_reg.source))
    else $error("fixed source address moved");
  a_dst_step_inc: assert property (step_done && $past(state_reg) == sbte_pkg::ST_DST
      && desc_reg.mode.dest_addr_step == sbte_pkg::AM_INC
      && desc_reg.mode.transfer_size == sbte_pkg::SIZE_BYTE
      |-> desc_reg.destination == $past(desc_reg.destination) + 32'h1)
    else $error("destination did not advance by one");
  a_count_down: assert property (step_done && $past(state_reg) == sbte_pkg::ST_DST
      |-> desc_reg.count == $past(desc_reg.count) - 16'h1)
    else $error("count not decremented");
  a_zero_stops: assert property (fin_zero && ch_rx_reg |=> !act_en_reg[sbte_pkg::ACT_RX_BIT]
      && rx_full_irq)
    else $error("finished receive channel not stopped");
  a_no_early_irq: assert property (fin_any && !fin_zero && !desc_reg.mode.irq_every_transfer
      && !ch_rx_reg && act_tx |=> !tx_empty_irq)
    else $error("interrupt before count finished");
  a_nmi_suspend: assert property (state_reg == sbte_pkg::ST_SUSP && nmi_s2_reg
      && !desc_reg.mode.nmi_behaviour |=> state_reg == sbte_pkg::ST_SUSP)
    else $error("transfer ran during nmi");
  a_tx_gate_off: assert property (tx_empty_evt && !ser_ctrl_reg[sbte_pkg::SC_TX_IRQ_ON]
      && !pend_tx_reg |=> !pend_tx_reg && !tx_empty_irq)
    else $error("gated transmit request leaked");
  a_rx_start: assert property (rx_req && act_rx |=> pend_rx_reg
      ##[0:4] state_reg == sbte_pkg::ST_FETCH)
    else $error("receive request did not start transfer");
  a_rx_source: assert property (state_reg == sbte_pkg::ST_SRC
      && desc_reg.source == sbte_pkg::RX_HOLD_ADDR
      |=> data_reg == $past(rx_hold_reg) && state_reg == sbte_pkg::ST_DST)
    else $error("receive holding byte not taken");
  a_wback_words: assert property (state_reg == sbte_pkg::ST_WBACK && mem_req_reg
      && idx_reg == 2'h1 |-> mem_we_reg && mem_wdata_reg == desc_reg.source)
    else $error("source not written back");

  c_rx_done: cover property (fin_zero && ch_rx_reg);
  c_tx_load: cover property (tx_load_reg ##[1:40] fin_any);
  c_nmi_wait: cover property (state_reg == sbte_pkg::ST_SUSP && nmi_s2_reg);
endmodule

// ==== testbench/sbte_mem.sv ====
// memory partner of the transfer engine
`timescale 1ns/100ps
module sbte_mem (
  input wire logic hclk,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] mem_be,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  logic [31:0] mem [64];
  logic tick = 1'b0;
  int wb_cnt = 0;
  initial mem_ack = 1'b0;
  // outside an answer the lines show the inverse, never a stale word
  assign mem_rdata = mem_ack ? mem[mem_addr[7:2]] : ~mem[mem_addr[7:2]];
  always @(posedge hclk) begin
    tick <= ~tick;
    // slow answers only on every other cycle
    mem_ack <= mem_req & ~mem_ack & (~slow | tick);
    if (mem_req & mem_ack & mem_we) begin
      for (int i = 0; i < 4; i++) begin
        if (mem_be[i]) mem[mem_addr[7:2]][8*i+:8] <= mem_wdata[8*i+:8];
      end
      if (mem_addr[3:0] == 4'h8) wb_cnt <= wb_cnt + 1;
    end
  end
endmodule

// ==== testbench/tb.sv ====
// self-checking bench of the serial byte transfer engine
`timescale 1ns/100ps
module tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0, nmi = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hr_q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic rx_full_evt = 1'b0, tx_empty_evt = 1'b0, rx_err_evt = 1'b0, tx_end_evt = 1'b0;
  logic multinode_evt = 1'b0, async_mode = 1'b0, multinode_mode = 1'b0;
  logic [7:0] rx_byte = 8'h00, tx_b = 8'h00;
  wire logic [31:0] hrdata, mem_addr, mem_wdata, mem_rdata;
  wire logic hready, hreadyout, hresp, mem_req, mem_we, mem_ack, tx_load, tx_on, rx_on;
  wire logic clk_internal, sck_dir_in, tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq;
  wire logic multinode_irq;
  wire logic [3:0] mem_be;
  wire logic [7:0] tx_byte;
  int fail_count = 0, check_count = 0, irq_n = 0, err_n = 0, tl_n = 0;
  logic [31:0] ra [4] = '{sbte_pkg::SER_CTRL_ADDR, sbte_pkg::DESC_BASE_ADDR,
    sbte_pkg::ACT_EN_ADDR, 32'h00000100};
  logic [31:0] rw [4] = '{32'hFFFFFFF1, 32'h1234ABCD, 32'hFFFF000C, 32'hFFFFFFFF};
  logic [31:0] rx [4] = '{32'h000000F1, 32'h0000ABCD, 32'h0000000C, 32'h00000000};
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  sbte_engine dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_be, .mem_rdata, .mem_ack, .tx_empty_evt, .rx_full_evt, .rx_err_evt, .tx_end_evt,
    .multinode_evt, .async_mode, .multinode_mode, .rx_byte, .nmi, .tx_byte, .tx_load,
    .tx_on, .rx_on, .clk_internal, .sck_dir_in, .tx_empty_irq, .rx_full_irq,
    .rx_error_irq, .tx_done_irq, .multinode_irq);
  sbte_mem ram (.hclk, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be,
    .mem_rdata, .mem_ack);
  // read data stands only up to the closing edge, so keep what that edge saw
  always @(posedge hclk) hr_q <= hrdata;
  always @(posedge hclk) begin
    if (rx_full_irq === 1'b1) irq_n <= irq_n + 1;
    if (rx_error_irq === 1'b1) err_n <= err_n + 1;
    if (tx_load === 1'b1) tx_b <= tx_byte;
    if (tx_load === 1'b1) tl_n <= tl_n + 1;
  end
  task automatic test_done(input int t);
    fail_count += t;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // bounded wait for hready, used by both phases
  task automatic rdy();
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 50) test_done(1);
  endtask
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    #1;
    rd = hr_q;
  endtask
  // k bit 0 receive full, bit 1 transmit empty, bit 2 receive error
  task automatic ev(input logic [2:0] k, input logic [7:0] b);
    @(posedge hclk);
    rx_byte <= b;
    {rx_err_evt, tx_empty_evt, rx_full_evt} <= k;
    @(posedge hclk);
    {rx_err_evt, tx_empty_evt, rx_full_evt} <= 3'h0;
  endtask
  task automatic wt(input int n);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge hclk);
      if (ram.wb_cnt == n) break;
    end
    if (i == 300) test_done(1);
  endtask
  initial begin
    ram.mem[8] = 32'h80000001;
    ram.mem[9] = 32'h00000050;
    ram.mem[10] = sbte_pkg::TX_HOLD_ADDR;
    ram.mem[20] = 32'h0000005A;
    ram.mem[12] = 32'h20000003;
    ram.mem[13] = sbte_pkg::RX_HOLD_ADDR;
    ram.mem[14] = 32'h00000040;
    ram.mem[16] = 32'h00000000;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(sbte_pkg::SER_CTRL_ADDR, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk({hresp, hreadyout, clk_internal, tx_on}, 4'h6);
    for (int k = 0; k < 4; k++) begin
      ahb(ra[k], 1'b1, rw[k]);
      ahb(ra[k], 1'b0, 32'h0);
      chk(rd, rx[k]);
    end
    ahb(sbte_pkg::DESC_BASE_ADDR, 1'b1, 32'h0);
    chk({tx_on, rx_on, sck_dir_in, clk_internal}, 4'hF);
    for (int k = 0; k < 3; k++) begin
      ev(3'h1, 8'hA1 + 8'(k) * 8'h11);
      wt(k + 1);
    end
    repeat (3) @(posedge hclk);
    chk(ram.mem[16], 32'h00C3B2A1);
    chk(ram.mem[12], 32'h20000000);
    chk(ram.mem[13], sbte_pkg::RX_HOLD_ADDR);
    chk(ram.mem[14], 32'h00000043);
    ahb(sbte_pkg::ACT_EN_ADDR, 1'b0, 32'h0);
    chk(rd, 32'h00000004);
    ev(3'h5, 8'hEE);
    repeat (4) @(posedge hclk);
    chk(32'(irq_n), 32'h2);
    chk(32'(err_n), 32'h1);
    chk(32'(ram.wb_cnt), 32'h3);
    // nmi holds the transmit transfer back until it is released
    slow <= 1'b1;
    nmi <= 1'b1;
    ev(3'h2, 8'h00);
    repeat (30) @(posedge hclk);
    chk(32'(tl_n), 32'h0);
    nmi <= 1'b0;
    wt(4);
    repeat (3) @(posedge hclk);
    chk(32'(tl_n), 32'h1);
    chk({24'h0, tx_b}, 32'h0000005A);
    chk(ram.mem[8], 32'h80000000);
    chk(ram.mem[9], 32'h00000051);
    test_done(0);
  end
endmodule
